// ---- gpc_pkg.sv ----
// package for the general purpose pin controller: offsets, fields, reset values, timing
// assumes a plain register port with 32-bit data and one-cycle read latency
package gpc_pkg;
   localparam int NUM_PINS = 3;
   localparam logic [7:0] ADDR_CFG = 8'h00;      // buffer type [2:0], polarity [10:8]
   localparam logic [7:0] ADDR_DATA_DIR = 8'h04; // data [2:0], direction [10:8]
   localparam logic [7:0] ADDR_IRQ = 8'h08;      // status [2:0] w1c, enable [10:8]
   localparam logic [7:0] ADDR_LED = 8'h0C;      // led enable [2:0]
   localparam logic [7:0] ADDR_SYS_IRQ = 8'h10;  // summary request [0]
   localparam int LO_POS = 0;
   localparam int HI_POS = 8;
   localparam logic [2:0] RST_DIR = 3'h0;
   localparam logic [2:0] RST_EN = 3'h0;
   localparam logic [2:0] RST_POL = 3'h0;
   localparam logic [2:0] RST_BUF = 3'h0;
   localparam logic [2:0] RST_DATA = 3'h7;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_LEVEL_NS = 40;
   // shortest qualifying pulse that must be caught, rounded down, at least one
   localparam int MIN_LEVEL_CYC = (MIN_LEVEL_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (MIN_LEVEL_NS / CLK_PERIOD_NS);
endpackage

// ---- gpc_pin_ctrl.sv ----
// pin controller top: three configurable pins, per-pin level interrupts, combined request
// assumes pins come from the board asynchronously; straps stable around reset release
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_ctrl (
   input wire logic clk_i,             // 100 MHz system clock
   input wire logic srst_i,            // synchronous reset, active high
   input wire logic [7:0] addr_i,      // register byte address
   input wire logic [31:0] wdata_i,    // write data
   input wire logic wr_i,              // write strobe
   input wire logic rd_i,              // read strobe
   output logic [31:0] rdata_o,        // read data, cycle after rd_i
   input wire logic [2:0] led_enable_straps_i, // led strap levels
   input wire logic [2:0] pin_i,       // pin levels from pads
   output logic [2:0] pin_o,           // pin drive value
   output logic [2:0] pin_oe_n_o,      // low while driving the pin
   output logic [2:0] pin_ie_o,        // pad input buffer enable
   output logic [2:0] pin_pu_o,        // pad pull-up enable
   output logic [2:0] led_mode_o,      // pin handed to led logic
   output logic irq_o                  // combined request to system interrupt controller
);
   logic [2:0] sync1_reg, sync2_reg;
   logic [2:0] dir_reg, dir_next;
   logic [2:0] buf_reg, buf_next;
   logic [2:0] pol_reg, pol_next;
   logic [2:0] en_reg, en_next;
   logic [2:0] dout_reg, dout_next;
   logic [2:0] led_reg, led_next;
   logic [2:0] sts_reg, sts_next;
   logic strap_pend_reg, strap_pend_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] active;
   logic [2:0] w1c;
   logic [2:0] data_view;

   // two-stage synchroniser; 40 ns is four cycles so any legal level is seen
   always_ff @(posedge clk_i) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
   end

   // per-pin level decode, pad controls and read view
   genvar g;
   generate
      for (g = 0; g < gpc_pkg::NUM_PINS; g++) begin : g_pin
         assign active[g] = pol_reg[g] ? sync2_reg[g] : ~sync2_reg[g];
         // input shows the pin, output shows the data register
         assign data_view[g] = dir_reg[g] ? dout_reg[g] : sync2_reg[g];
         // open-drain drives only a zero; push-pull drives the bit
         assign pin_o[g] = led_reg[g] ? 1'b0 : (buf_reg[g] ? 1'b0 : dout_reg[g]);
         assign pin_oe_n_o[g] = led_reg[g] ? 1'b1 :
                                ~(dir_reg[g] & (~buf_reg[g] | ~dout_reg[g]));
         assign pin_ie_o[g] = ~led_reg[g] & ~dir_reg[g];
         assign pin_pu_o[g] = ~led_reg[g];
      end
   endgenerate

   assign w1c = (wr_i && addr_i == gpc_pkg::ADDR_IRQ) ? wdata_i[2:0] : 3'h0;

   // register writes, sticky status and read mux
   always_comb begin
      dir_next = dir_reg;
      buf_next = buf_reg;
      pol_next = pol_reg;
      en_next = en_reg;
      dout_next = dout_reg;
      led_next = led_reg;
      strap_pend_next = 1'b0;
      rdata_next = 32'h0;
      // set beats write-one-clear while the level holds
      sts_next = (sts_reg & ~w1c) | active;
      // straps caught in the cycle after reset release, not under reset
      if (strap_pend_reg) begin
         led_next = led_enable_straps_i;
      end
      if (wr_i) begin
         case (addr_i)
            gpc_pkg::ADDR_CFG: begin
               buf_next = wdata_i[gpc_pkg::LO_POS +: 3];
               pol_next = wdata_i[gpc_pkg::HI_POS +: 3];
            end
            gpc_pkg::ADDR_DATA_DIR: begin
               dout_next = wdata_i[gpc_pkg::LO_POS +: 3];
               dir_next = wdata_i[gpc_pkg::HI_POS +: 3];
            end
            gpc_pkg::ADDR_IRQ: begin
               en_next = wdata_i[gpc_pkg::HI_POS +: 3];
            end
            gpc_pkg::ADDR_LED: begin
               led_next = wdata_i[gpc_pkg::LO_POS +: 3];
            end
            default: begin
            end
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            gpc_pkg::ADDR_CFG: begin
               rdata_next[gpc_pkg::LO_POS +: 3] = buf_reg;
               rdata_next[gpc_pkg::HI_POS +: 3] = pol_reg;
            end
            gpc_pkg::ADDR_DATA_DIR: begin
               rdata_next[gpc_pkg::LO_POS +: 3] = data_view;
               rdata_next[gpc_pkg::HI_POS +: 3] = dir_reg;
            end
            gpc_pkg::ADDR_IRQ: begin
               rdata_next[gpc_pkg::LO_POS +: 3] = sts_reg;
               rdata_next[gpc_pkg::HI_POS +: 3] = en_reg;
            end
            gpc_pkg::ADDR_LED: begin
               rdata_next[gpc_pkg::LO_POS +: 3] = led_reg;
            end
            gpc_pkg::ADDR_SYS_IRQ: begin
               rdata_next[0] = irq_o;
            end
            default: begin
               rdata_next = 32'h0; // unmapped reads as zero
            end
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dir_reg <= gpc_pkg::RST_DIR;
         en_reg <= gpc_pkg::RST_EN;
         pol_reg <= gpc_pkg::RST_POL;
         buf_reg <= gpc_pkg::RST_BUF;
         dout_reg <= gpc_pkg::RST_DATA;
         led_reg <= 3'h0;
         sts_reg <= 3'h0;
         strap_pend_reg <= 1'b1;
         rdata_reg <= 32'h0;
      end else begin
         dir_reg <= dir_next;
         en_reg <= en_next;
         pol_reg <= pol_next;
         buf_reg <= buf_next;
         dout_reg <= dout_next;
         led_reg <= led_next;
         sts_reg <= sts_next;
         strap_pend_reg <= strap_pend_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign led_mode_o = led_reg;
   assign irq_o = |(sts_reg & en_reg);
endmodule
`default_nettype wire

// ---- gpc_pin_ctrl_chk.sv ----
// checker for the pin controller, port relations only
// assumes it is bound into gpc_pin_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module gpc_chk (
   input wire logic clk_i, // clock
   input wire logic srst_i, // reset
   input wire logic [7:0] addr_i, // address
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   input wire logic [31:0] rdata_o, // read data
   input wire logic [2:0] led_enable_straps_i, // straps
   input wire logic [2:0] pin_oe_n_o, // low while driving
   input wire logic [2:0] pin_ie_o, // input buffer
   input wire logic [2:0] pin_pu_o, // pull-up
   input wire logic [2:0] led_mode_o, // led handoff
   input wire logic irq_o // combined request
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // reset checks cannot use the default disable, it would hide them
   property p_rst_in; disable iff (1'b0) srst_i |=> pin_oe_n_o == 3'h7; endproperty
   a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
   property p_rst_irq; disable iff (1'b0) srst_i |=> !irq_o; endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("request after reset");
   property p_straps; $fell(srst_i) |=> led_mode_o == $past(led_enable_straps_i); endproperty
   a_straps: assert property (p_straps) else $error("led mode not from straps");
   property p_ie_off; (~pin_oe_n_o & pin_ie_o) == 3'h0; endproperty
   a_ie_off: assert property (p_ie_off) else $error("input buffer on while driving");
   property p_pu_on; (~led_mode_o & ~pin_pu_o) == 3'h0; endproperty
   a_pu_on: assert property (p_pu_on) else $error("pull-up off on general pin");
   property p_led; (led_mode_o & (pin_ie_o | pin_pu_o | ~pin_oe_n_o)) == 3'h0; endproperty
   a_led: assert property (p_led) else $error("led pin pad not released");
   property p_sum; rd_i && addr_i == gpc_pkg::ADDR_SYS_IRQ |=> rdata_o == {31'h0, $past(irq_o)};
   endproperty
   a_sum: assert property (p_sum) else $error("summary bit differs from request");
   property p_sticky; irq_o && !wr_i |=> irq_o; endproperty
   a_sticky: assert property (p_sticky) else $error("request dropped without write");
endmodule
bind gpc_pin_ctrl gpc_chk u_chk (.*);
`default_nettype wire

// ---- gpc_board.sv ----
// board model on the three pins: external drivers and pad pull-ups
// assumes the bench sets which pins the board drives and to what level
`timescale 1ns/1ps
`default_nettype none
module gpc_board (
   input wire logic clk_i, // clock
   input wire logic [2:0] pin_o, // design drive value
   input wire logic [2:0] pin_oe_n_o, // design drive enable, low
   input wire logic [2:0] pin_pu_o, // pull-up enable
   input wire logic [2:0] ext_en_i, // board drives pin
   input wire logic [2:0] ext_i, // board level
   output logic [2:0] pin_i // resolved pin level
);
   logic tog = 1'b0;
   // a floating pin wanders so a stale level is never taken for a drive
   always @(posedge clk_i) tog <= ~tog;
   // design drive first, then board, then pull-up; undriven open-drain floats high
   assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_en_i & ext_i)
      | (pin_oe_n_o & ~ext_en_i & (pin_pu_o | {3{tog}}));
endmodule
`default_nettype wire

// ---- test_gpc_pin_ctrl.sv ----
// bench for the pin controller: register tasks, board model, checks
// assumes gpc_pkg, gpc_board and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_gpc_pin_ctrl;
   logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, irq_o;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o, v;
   logic [2:0] straps = 3'h4, ext_en = 3'h0, ext = 3'h0, pin_i, pin_o, oe_n, ie, pu, led;
   int fails = 0;
   int n_checks = 0;
   initial forever #5 clk_i = ~clk_i;
   gpc_pin_ctrl DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .led_enable_straps_i(straps), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_n_o(oe_n), .pin_ie_o(ie), .pin_pu_o(pu), .led_mode_o(led),
      .irq_o(irq_o));
   gpc_board u_board (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pin_pu_o(pu),
      .ext_en_i(ext_en), .ext_i(ext), .pin_i(pin_i));
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // one-cycle strobes; outputs are looked at 1 ns after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic wrap_up();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(gpc_pkg::ADDR_CFG);
      chk("polarity", v[10:8], 3'h0);
      rd(gpc_pkg::ADDR_DATA_DIR);
      chk("direction", v[10:8], 3'h0);
      rd(gpc_pkg::ADDR_IRQ);
      chk("enable", v[10:8], 3'h0);
      rd(gpc_pkg::ADDR_LED);
      chk("led", v, 32'h4);
      chk("led_pads", {led, pu, ie}, 9'h11B);
      @(posedge clk_i);
      #1 chk("rdata_one_cycle", rdata_o, 32'h0);
      wr(gpc_pkg::ADDR_LED, 32'h0);
      wr(gpc_pkg::ADDR_DATA_DIR, 32'h0702);
      chk("push_pull", {oe_n, pin_o}, 6'h02);
      wr(gpc_pkg::ADDR_CFG, 32'h3);
      chk("open_drain", {oe_n, pin_o, ie}, 9'h080);
      ext_en <= 3'h7;
      ext <= 3'h5;
      wr(gpc_pkg::ADDR_DATA_DIR, 32'h0);
      repeat (4) @(posedge clk_i);
      rd(gpc_pkg::ADDR_DATA_DIR);
      chk("input", v[2:0], 3'h5);
      wr(gpc_pkg::ADDR_CFG, 32'h300);
      ext <= 3'h1;
      repeat (4) @(posedge clk_i);
      wr(gpc_pkg::ADDR_IRQ, 32'h7);
      rd(gpc_pkg::ADDR_IRQ);
      chk("status", v[2:0], 3'h5);
      wr(gpc_pkg::ADDR_IRQ, 32'h200);
      chk("masked", irq_o, 1'h0);
      ext <= 3'h3;
      repeat (5) @(posedge clk_i);
      ext <= 3'h1;
      repeat (4) @(posedge clk_i);
      chk("request", irq_o, 1'h1);
      rd(gpc_pkg::ADDR_SYS_IRQ);
      chk("summary", v, 32'h1);
      wr(gpc_pkg::ADDR_IRQ, 32'h202);
      chk("cleared", irq_o, 1'h0);
      rd(8'h20);
      chk("unmapped", v, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
